// *** design/pptr_pkg.sv ***
package pptr_pkg;
    // Register offsets
    localparam logic [15:0] OFS_STEER = 16'h20C8;
    localparam logic [15:0] OFS_DC_INDEX = 16'h2500;
    localparam logic [15:0] OFS_DC_DATA = 16'h2504;
    localparam logic [15:0] OFS_DIR_BASE = 16'h2518;
    // Reset values
    localparam logic [5:0] STEER_RESET = 6'h00;
    localparam logic [14:0] DIR_BASE_RESET = 15'h0000;
    localparam logic [9:0] DC_INDEX_RESET = 10'h000;
    localparam logic [31:0] CL_VALID_RESET = 32'hFFFFFFFF;
    // Steering field layout
    localparam int STEER_LSB = 0;
    localparam int STEER_MASK_LSB = 16;
    localparam logic [5:0] STEER_WR_MASK = 6'h3B;
    localparam int STEER_BATCH = 5;
    localparam int STEER_INDIRECT = 4;
    localparam int STEER_VERTEX = 3;
    localparam int STEER_SAMPLER = 1;
    localparam int STEER_RENDER = 0;
    // Other field positions
    localparam int DIR_BASE_LSB = 16;
    localparam int DC_INDEX_LSB = 2;
    localparam int ENT_ADDR_LSB = 12;
    localparam int ENT_EXT_LSB = 4;
    localparam int ENT_HOST_BIT = 3;
    localparam int ENT_TYPE_LSB = 1;
    localparam int ENT_VALID_BIT = 0;
    localparam int DIR_IDX_LSB = 22;
    localparam int TBL_IDX_LSB = 12;
    localparam int GROUP_LSB = 4;
    localparam int DC_DEPTH = 1024;
    // Mapping types
    localparam logic [1:0] MAP_UNSNOOPED = 2'h0;
    localparam logic [1:0] MAP_SNOOPED = 2'h3;
    // Clients of the translator
    typedef enum logic [2:0]
    {
        CL_BATCH,
        CL_INDIRECT,
        CL_VERTEX,
        CL_SAMPLER,
        CL_RENDER,
        CL_BLIT,
        CL_MI
    } pptr_client_type;
endpackage

// *** design/pptr_translator.sv ***
`timescale 1ns/100ps
module pptr_translator
    import pptr_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // Memory-mapped register access
    input wire logic mmio_wr_en_in,
    input wire logic mmio_rd_en_in,
    input wire logic [15:0] mmio_addr_in,
    input wire logic [31:0] mmio_wdata_in,
    output logic [31:0] mmio_rdata_out,
    output logic mmio_rvalid_out,
    // Table control levels
    input wire logic table_enable_in,
    input wire logic mode_ppas_enable_in,
    input wire logic two_level_in,
    input wire logic [35:0] table_base_in,
    input wire logic [35:0] global_base_in,
    // Context restore and save
    input wire logic ctx_restore_in,
    input wire logic ctx_reg_wr_in,
    input wire logic [31:0] ctx_steer_in,
    input wire logic [31:0] ctx_dir_base_in,
    input wire logic [31:0] ctx_cl_valid_in,
    input wire logic dc_wr_in,
    input wire logic [9:0] dc_wr_index_in,
    input wire logic [31:0] dc_wr_data_in,
    output logic [31:0] ctx_steer_out,
    output logic [31:0] ctx_dir_base_out,
    // Translation request
    input wire logic req_valid_in,
    input wire logic [2:0] req_client_in,
    input wire logic [31:0] req_addr_in,
    input wire logic req_global_sel_in,
    input wire logic req_privileged_in,
    input wire logic req_cpu_read_in,
    input wire logic req_instr_in,
    output logic req_ready_out,
    // Entry fetch from memory
    output logic mem_rd_out,
    output logic [35:0] mem_addr_out,
    input wire logic mem_resp_valid_in,
    input wire logic [31:0] mem_resp_data_in,
    // Translation result
    output logic resp_valid_out,
    output logic [35:0] resp_phys_out,
    output logic resp_snoop_out,
    output logic resp_per_process_out,
    output logic resp_error_out,
    output logic resp_denied_out,
    // Status
    input wire logic err_clear_in,
    output logic pte_error_out,
    output logic fatal_hang_out
);

    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_WAIT} pptr_state_type;
    ////////////////////////////////////////////////////////////////////
    // Declarations
    logic [5:0] steer_reg;
    logic [14:0] dir_base_reg;
    logic [9:0] dc_index_reg;
    logic [31:0] cl_valid_reg;
    logic [31:0] dc_mem [0:DC_DEPTH-1];
    logic [31:0] dc_rd_word;
    pptr_state_type state_reg;
    logic [31:0] addr_reg;
    logic pp_reg, cpu_rd_reg, instr_reg;
    logic [35:0] pte_addr_reg;
    logic pp_active, use_pp, denied, pde_ok, take, pte_bad;
    logic [31:0] directory_entry;
    logic [5:0] steer_next;
    // Register-select decode
    function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
        hit = (a == o);
    endfunction
    // Masked steering update
    function automatic logic [5:0] masked(input logic [5:0] old,
                                          input logic [31:0] wd);
        logic [5:0] m;
        logic [5:0] v;
        m = wd[STEER_MASK_LSB +: 6] & STEER_WR_MASK;
        v = wd[STEER_LSB +: 6];
        masked = (old & ~m) | (v & m);
    endfunction
    ////////////////////////////////////////////////////////////////////
    // Table selection
    assign pp_active = table_enable_in & mode_ppas_enable_in;
    always_comb
    begin
        use_pp = 1'b0;
        denied = 1'b0;
        if (req_client_in == CL_MI)
        begin
            use_pp = pp_active & ~req_global_sel_in;
            // With per-process tables active, global memory needs ring or secure batch rights
            denied = (~use_pp) & ~req_privileged_in & pp_active;
        end
        else if (pp_active & two_level_in)
        begin
            use_pp = 1'b1;
        end
        else if (pp_active)
        begin
            case (req_client_in)
                CL_BATCH: use_pp = steer_reg[STEER_BATCH];
                CL_INDIRECT: use_pp = steer_reg[STEER_INDIRECT];
                CL_VERTEX: use_pp = steer_reg[STEER_VERTEX];
                CL_SAMPLER: use_pp = steer_reg[STEER_SAMPLER];
                CL_RENDER: use_pp = steer_reg[STEER_RENDER];
                default: use_pp = 1'b0;
            endcase
        end
    end

    // Directory lookup from the on-chip cache
    assign directory_entry = dc_mem[req_addr_in[DIR_IDX_LSB +: 10]];
    assign pde_ok = directory_entry[ENT_VALID_BIT]
        & cl_valid_reg[req_addr_in[DIR_IDX_LSB + GROUP_LSB +: 5]]
        & ~req_addr_in[31];
    assign take = req_valid_in & (state_reg == ST_IDLE) & ~fatal_hang_out;
    assign req_ready_out = (state_reg == ST_IDLE) & ~fatal_hang_out;
    assign steer_next = masked(steer_reg, mmio_wdata_in);
    ////////////////////////////////////////////////////////////////////
    // Steering register: software write and context restore
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
            steer_reg <= STEER_RESET;
        else if (ctx_reg_wr_in)
            steer_reg <= ctx_steer_in[5:0] & STEER_WR_MASK;
        else if (mmio_wr_en_in && hit(mmio_addr_in, OFS_STEER))
            steer_reg <= steer_next;
    end

    // Directory base and cacheline valid: context restored
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            dir_base_reg <= DIR_BASE_RESET;
            cl_valid_reg <= CL_VALID_RESET;
        end
        else if (ctx_reg_wr_in)
        begin
            dir_base_reg <= ctx_dir_base_in[DIR_BASE_LSB +: 15];
            cl_valid_reg <= ctx_cl_valid_in;
        end
        else if (mmio_wr_en_in && hit(mmio_addr_in, OFS_DIR_BASE))
            dir_base_reg <= mmio_wdata_in[DIR_BASE_LSB +: 15];
    end

    // Context save image
    assign ctx_steer_out = {26'h0000000, steer_reg};
    assign ctx_dir_base_out = {1'b0, dir_base_reg, 16'h0000};

    // Directory cache index
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
            dc_index_reg <= DC_INDEX_RESET;
        else if (mmio_wr_en_in && hit(mmio_addr_in, OFS_DC_INDEX))
            dc_index_reg <= mmio_wdata_in[DC_INDEX_LSB +: 10];
    end

    // Directory cache fill, restore only, enabled groups only
    always_ff @(posedge clock_in)
    begin
        if (ctx_restore_in && dc_wr_in && !dc_wr_index_in[9]
            && cl_valid_reg[dc_wr_index_in[GROUP_LSB +: 5]])
            dc_mem[dc_wr_index_in] <= dc_wr_data_in;
    end

    // Debug read word, directory format with host bit
    always_comb
    begin
        dc_rd_word = dc_mem[dc_index_reg];
        dc_rd_word[11:8] = 4'h0;
        dc_rd_word[2:1] = 2'h0;
    end
    ////////////////////////////////////////////////////////////////////
    // Register read path
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            mmio_rdata_out <= 32'h00000000;
            mmio_rvalid_out <= 1'b0;
        end
        else
        begin
            mmio_rvalid_out <= mmio_rd_en_in;
            if (!mmio_rd_en_in)
                mmio_rdata_out <= 32'h00000000;
            else if (hit(mmio_addr_in, OFS_STEER))
                mmio_rdata_out <= {26'h0000000, steer_reg};
            else if (hit(mmio_addr_in, OFS_DC_INDEX))
                mmio_rdata_out <= {20'h00000, dc_index_reg, 2'h0};
            else if (hit(mmio_addr_in, OFS_DC_DATA))
                mmio_rdata_out <= dc_rd_word;
            else if (hit(mmio_addr_in, OFS_DIR_BASE))
                mmio_rdata_out <= {1'b0, dir_base_reg, 16'h0000};
            else
                mmio_rdata_out <= 32'h00000000;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Walk state machine
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
            state_reg <= ST_IDLE;
        else
        begin
            case (state_reg)
                ST_IDLE:
                    if (take && !denied
                        && !(use_pp && two_level_in && !pde_ok))
                        state_reg <= ST_FETCH;
                ST_FETCH:
                    state_reg <= ST_WAIT;
                ST_WAIT:
                    if (mem_resp_valid_in)
                        state_reg <= ST_IDLE;
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // Request capture and entry address
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            addr_reg <= 32'h00000000;
            pp_reg <= 1'b0;
            cpu_rd_reg <= 1'b0;
            instr_reg <= 1'b0;
            pte_addr_reg <= 36'h000000000;
        end
        else if (take)
        begin
            addr_reg <= req_addr_in;
            pp_reg <= use_pp;
            cpu_rd_reg <= req_cpu_read_in;
            instr_reg <= req_instr_in;
            if (!use_pp)
                pte_addr_reg <= global_base_in
                    + {14'h0000, req_addr_in[31:TBL_IDX_LSB], 2'h0};
            else if (two_level_in)
                pte_addr_reg <= {directory_entry[ENT_EXT_LSB +: 4],
                    directory_entry[31:ENT_ADDR_LSB],
                    req_addr_in[TBL_IDX_LSB +: 10], 2'h0};
            else
                pte_addr_reg <= table_base_in
                    + {14'h0000, req_addr_in[31:TBL_IDX_LSB], 2'h0};
        end
    end

    // Entry fetch strobe
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            mem_rd_out <= 1'b0;
            mem_addr_out <= 36'h000000000;
        end
        else
        begin
            mem_rd_out <= (state_reg == ST_FETCH);
            if (state_reg == ST_FETCH)
                mem_addr_out <= pte_addr_reg;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Translation result
    assign pte_bad = ~mem_resp_data_in[ENT_VALID_BIT] & ~cpu_rd_reg;
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            resp_valid_out <= 1'b0;
            resp_phys_out <= 36'h000000000;
            resp_snoop_out <= 1'b0;
            resp_per_process_out <= 1'b0;
            resp_error_out <= 1'b0;
            resp_denied_out <= 1'b0;
        end
        else
        begin
            resp_valid_out <= 1'b0;
            resp_error_out <= 1'b0;
            resp_denied_out <= 1'b0;
            if (take && denied)
            begin
                resp_valid_out <= 1'b1;
                resp_denied_out <= 1'b1;
                resp_per_process_out <= 1'b0;
                resp_phys_out <= 36'h000000000;
                resp_snoop_out <= 1'b0;
            end
            else if (state_reg == ST_WAIT && mem_resp_valid_in)
            begin
                resp_valid_out <= 1'b1;
                resp_per_process_out <= pp_reg;
                resp_phys_out <= {mem_resp_data_in[ENT_EXT_LSB +: 4],
                    mem_resp_data_in[31:ENT_ADDR_LSB],
                    addr_reg[TBL_IDX_LSB-1:0]};
                resp_error_out <= pte_bad;
                resp_snoop_out <= mem_resp_data_in[ENT_VALID_BIT]
                    & (mem_resp_data_in[ENT_TYPE_LSB +: 2] == MAP_SNOOPED)
                    & ~instr_reg;
            end
        end
    end
    // Sticky error flags; a new error wins over a clear
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            pte_error_out <= 1'b0;
            fatal_hang_out <= 1'b0;
        end
        else
        begin
            if (state_reg == ST_WAIT && mem_resp_valid_in && pte_bad)
                pte_error_out <= 1'b1;
            else if (err_clear_in)
                pte_error_out <= 1'b0;
            if (take && !denied && use_pp && two_level_in && !pde_ok)
                fatal_hang_out <= 1'b1;
        end
    end
endmodule

// *** test/pptr_translator_props.sv ***
`timescale 1ns/100ps
module pptr_translator_props
    import pptr_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // Register and request side
    input wire logic mmio_rd_en_in,
    input wire logic mmio_rvalid_out,
    input wire logic req_valid_in,
    input wire logic req_ready_out,
    input wire logic table_enable_in,
    input wire logic mode_ppas_enable_in,
    input wire logic err_clear_in,
    // Entry fetch
    input wire logic mem_rd_out,
    input wire logic mem_resp_valid_in,
    input wire logic [31:0] mem_resp_data_in,
    // Results and status
    input wire logic resp_valid_out,
    input wire logic [35:0] resp_phys_out,
    input wire logic resp_snoop_out,
    input wire logic resp_per_process_out,
    input wire logic resp_error_out,
    input wire logic resp_denied_out,
    input wire logic pte_error_out,
    input wire logic fatal_hang_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (srst_in);

    ////////////////////////////////////////
    // Register read timing
    a_read_answer: assert property (
        mmio_rd_en_in |=> mmio_rvalid_out) else $error("no read answer");
    // Fetch launch and result
    a_fetch_launch: assert property (
        mem_rd_out |-> $past(req_valid_in && req_ready_out, 2))
        else $error("fetch without request");
    a_resp_follows: assert property (
        mem_resp_valid_in && !req_ready_out |=>
        resp_valid_out || resp_error_out) else $error("no result");
    a_phys_format: assert property (
        resp_valid_out && !resp_denied_out && !resp_error_out |->
        resp_phys_out[35:12] == {$past(mem_resp_data_in[7:4]),
        $past(mem_resp_data_in[31:12])}) else $error("bad address");
    a_snoop_type: assert property (
        resp_valid_out && resp_snoop_out |->
        $past(mem_resp_data_in[2:1]) == 2'h3) else $error("bad snoop");
    a_error_cause: assert property (
        resp_error_out |-> $past(mem_resp_valid_in)
        && !$past(mem_resp_data_in[0])) else $error("stray error");
    a_global_when_off: assert property (
        resp_valid_out && !(table_enable_in && mode_ppas_enable_in) |->
        !resp_per_process_out) else $error("table not global");
    a_denied_early: assert property (
        resp_denied_out |-> $past(req_valid_in && req_ready_out)
        && !mem_rd_out) else $error("late denial");
    a_hang_sticky: assert property (
        fatal_hang_out |=> fatal_hang_out && !req_ready_out)
        else $error("hang released");
    a_error_sticky: assert property (
        pte_error_out && !err_clear_in |=> pte_error_out)
        else $error("error flag lost");
    // Main scenarios seen
    c_denied: cover property (resp_denied_out);
    c_error: cover property (resp_error_out);
    c_hang: cover property (fatal_hang_out);
endmodule

// *** test/pptr_mem_model.sv ***
`timescale 1ns/100ps
module pptr_mem_model
(
    // Clock
    input wire logic clock_in,
    // Fetch request and chosen answer
    input wire logic mem_rd_in,
    input wire logic [31:0] entry_in,
    input wire logic [3:0] delay_in,
    // Answer
    output logic mem_resp_valid_out = 1'b0,
    output logic [31:0] mem_resp_data_out = 32'h00000000
);
    int cnt = -1;

    ////////////////////////////////////////
    // Answer each fetch after a chosen delay; stale data inverted
    always @(negedge clock_in)
    begin
        mem_resp_valid_out <= 1'b0;
        if (mem_resp_valid_out)
            mem_resp_data_out <= ~mem_resp_data_out;
        if (mem_rd_in)
            cnt <= delay_in;
        else if (cnt == 0)
        begin
            mem_resp_valid_out <= 1'b1;
            mem_resp_data_out <= entry_in;
            cnt <= -1;
        end
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
endmodule

// *** test/pptr_translator_tb.sv ***
`timescale 1ns/100ps
module pptr_translator_tb import pptr_pkg::*;;
    logic clock_in = 0, srst_in = 1, mmio_wr_en_in = 0, mmio_rd_en_in = 0;
    logic [15:0] mmio_addr_in = 16'h0000;
    logic [31:0] mmio_wdata_in = 32'h0, mmio_rdata_out, ctx_steer_out;
    logic [31:0] ctx_dir_base_out, ctx_steer_in = 32'h0, rdata, entry;
    logic [31:0] ctx_dir_base_in = 32'h0, ctx_cl_valid_in = 32'hFFFFFFFF;
    logic [31:0] dc_wr_data_in = 32'h0, req_addr_in = 32'h0, mem_resp_data_in;
    logic mmio_rvalid_out, table_enable_in = 0, mode_ppas_enable_in = 0;
    logic two_level_in = 0, ctx_restore_in = 0, ctx_reg_wr_in = 0;
    logic [35:0] table_base_in = 36'h100000, global_base_in = 36'h200000;
    logic [35:0] mem_addr_out, resp_phys_out, got_addr, got_phys;
    logic [9:0] dc_wr_index_in = 10'h0;
    logic [2:0] req_client_in = 3'h0;
    logic [3:0] delay = 4'h0;
    logic [4:0] got;
    logic dc_wr_in = 0, req_valid_in = 0, req_global_sel_in = 0;
    logic req_privileged_in = 0, req_cpu_read_in = 0, req_instr_in = 0;
    logic req_ready_out, mem_rd_out, mem_resp_valid_in, resp_valid_out;
    logic resp_snoop_out, resp_per_process_out, resp_error_out;
    logic resp_denied_out, err_clear_in = 0, pte_error_out, fatal_hang_out;
    int num_errors = 0, n_tests = 0;

    pptr_translator pptr_translator_i (.*);
    pptr_mem_model pptr_mem_model_i (.clock_in(clock_in),
        .mem_rd_in(mem_rd_out), .entry_in(entry), .delay_in(delay),
        .mem_resp_valid_out(mem_resp_valid_in),
        .mem_resp_data_out(mem_resp_data_in));

    // Clock
    always #2 clock_in = ~clock_in;

    ////////////////////////////////////////
    // Shared tasks
    task automatic chk(string what, logic [35:0] exp, logic [35:0] seen);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(logic [15:0] a, logic [31:0] d);
        @(negedge clock_in);
        {mmio_wr_en_in, mmio_addr_in, mmio_wdata_in} = {1'b1, a, d};
        @(negedge clock_in);
        mmio_wr_en_in = 0;
    endtask

    task automatic rd(logic [15:0] a);
        @(negedge clock_in);
        {mmio_rd_en_in, mmio_addr_in} = {1'b1, a};
        @(negedge clock_in);
        mmio_rd_en_in = 0;
        rdata = mmio_rdata_out;
    endtask

    task automatic pulse(ref logic s);
        @(negedge clock_in);
        s = 1;
        @(negedge clock_in);
        s = 0;
    endtask

    // Translate: f = {global_sel, privileged, cpu_read, instr}
    task automatic xl(logic [2:0] c, logic [31:0] a, logic [3:0] f);
        @(negedge clock_in);
        {req_valid_in, req_client_in, req_addr_in} = {1'b1, c, a};
        {req_global_sel_in, req_privileged_in, req_cpu_read_in,
            req_instr_in} = f;
        @(negedge clock_in);
        {req_valid_in, got, got_addr} = 0;
        repeat (14)
        begin
            if (mem_rd_out === 1'b1)
                got_addr = mem_addr_out;
            if ((resp_valid_out | resp_error_out | resp_denied_out) === 1)
            begin
                got_phys = resp_phys_out;
                got = {resp_per_process_out, resp_snoop_out, resp_error_out,
                    resp_denied_out, 1'b1};
            end
            @(negedge clock_in);
        end
    endtask

    ////////////////////////////////////////
    // Scenarios
    task automatic t_regs();
        rd(OFS_STEER);
        chk("steer reset", 0, rdata);
        rd(16'h2000);
        chk("unmapped", 0, rdata);
        wr(OFS_DC_INDEX, 32'hFFFFFFFF);
        rd(OFS_DC_INDEX);
        chk("index", 36'hFFC, rdata);
        wr(OFS_DIR_BASE, 32'hFFFFFFFF);
        rd(OFS_DIR_BASE);
        chk("dir base", 36'h7FFF0000, rdata);
        chk("dir save", 36'h7FFF0000, ctx_dir_base_out);
        wr(OFS_STEER, 32'h0000003F);
        rd(OFS_STEER);
        chk("steer unmasked", 0, rdata);
        wr(OFS_STEER, 32'h003F003F);
        wr(OFS_STEER, 32'h00010000);
        rd(OFS_STEER);
        chk("steer masked", 36'h3A, rdata);
        chk("steer save", 36'h3A, ctx_steer_out);
        ctx_steer_in = 32'h00000029;
        ctx_cl_valid_in = 32'h00000001;
        ctx_dir_base_in = 32'h12340000;
        pulse(ctx_reg_wr_in);
        rd(OFS_STEER);
        chk("steer restore", 36'h29, rdata);
        rd(OFS_DIR_BASE);
        chk("dir restore", 36'h12340000, rdata);
        $display("test regs done");
    endtask

    task automatic t_flat();
        logic [5:0] pp = 6'h15;
        {table_enable_in, mode_ppas_enable_in} = 2'b11;
        entry = 32'hABCDE0A1;
        for (int c = 0; c < 6; c++)
        begin
            delay = 4'(c);
            xl(3'(c), 32'h00003123, 4'h0);
            chk("table", pp[c], got[4]);
            chk("fetch", (pp[c] ? 36'h100000 : 36'h200000) + 36'hC,
                got_addr);
            chk("phys", 36'hAABCDE123, got_phys);
        end
        for (int m = 0; m < 2; m++)
        begin
            {table_enable_in, mode_ppas_enable_in} = m ? 2'b10 : 2'b01;
            xl(CL_BATCH, 32'h00003123, 4'h0);
            chk("global", 1'b0, got[4]);
        end
        $display("test flat done");
    endtask

    task automatic t_entry();
        entry = 32'h12345007;
        xl(CL_RENDER, 32'h0, 4'h0);
        chk("snoop", 1'b1, got[3]);
        xl(CL_RENDER, 32'h0, 4'h1);
        chk("instr snoop", 5'h01, got);
        entry = 32'h12345000;
        xl(CL_RENDER, 32'h0, 4'h0);
        chk("invalid", 1'b1, got[2]);
        chk("sticky", 1'b1, pte_error_out);
        xl(CL_RENDER, 32'h0, 4'h2);
        chk("cpu read", 1'b0, got[2]);
        pulse(err_clear_in);
        chk("clear", 1'b0, pte_error_out);
        $display("test entry done");
    endtask

    task automatic t_mi();
        {table_enable_in, mode_ppas_enable_in} = 2'b11;
        entry = 32'h00001001;
        xl(CL_MI, 32'h5000, 4'h8);
        chk("denied", 6'h03, {got_addr[0], got});
        xl(CL_MI, 32'h5000, 4'hC);
        chk("privileged", 36'h200014, got_addr);
        xl(CL_MI, 32'h5000, 4'h0);
        chk("mi table", 1'b1, got[4]);
        $display("test mi done");
    endtask

    task automatic t_two();
        ctx_restore_in = 1;
        {dc_wr_index_in, dc_wr_data_in} = {10'h0, 32'h0004BF1F};
        pulse(dc_wr_in);
        {dc_wr_index_in, dc_wr_data_in} = {10'h3, 32'h11111001};
        pulse(dc_wr_in);
        ctx_restore_in = 0;
        dc_wr_data_in = 32'h22222001;
        pulse(dc_wr_in);
        wr(OFS_DC_INDEX, 32'h0000000C);
        rd(OFS_DC_DATA);
        chk("cache gated", 36'h11111001, rdata);
        wr(OFS_DC_INDEX, 32'h00000000);
        rd(OFS_DC_DATA);
        chk("cache data", 36'h0004B019, rdata);
        two_level_in = 1;
        entry = 32'hABCDE0A1;
        xl(CL_BLIT, 32'h00005ABC, 4'h0);
        chk("walk", 36'h10004B014, got_addr);
        chk("blit table", 1'b1, got[4]);
        xl(CL_RENDER, 32'h04000000, 4'h0);
        chk("hang", 3'h4, {fatal_hang_out, req_ready_out, got[0]});
        $display("test two level done");
    endtask

    ////////////////////////////////////////
    // Verdict, watchdog and main sequence
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        #(4 * 6000);
        num_errors++;
        give_verdict();
    end

    initial
    begin
        repeat (12) @(posedge clock_in);
        @(negedge clock_in);
        srst_in = 0;
        t_regs();
        t_flat();
        t_entry();
        t_mi();
        t_two();
        give_verdict();
    end
endmodule

bind pptr_translator pptr_translator_props pptr_translator_props_i (.*);
